// file: sixp_port.sv
`timescale 1ns/1ps
module sixp_port
    import sixp_pkg::*;
(
    input wire logic MCLK_I,
    input wire logic RST_N_I,
    input wire logic CE_I,
    input wire sixp_pkg::sixp_cfg_t CFG_I,
    input wire logic DATA_WR_I,
    input wire logic DIR_LOAD_I,
    input wire logic [7:0] WDATA_I,
    input wire logic DATA_RD_I,
    output logic [7:0] RDATA_O,
    input wire logic [5:0] PIN_I,
    output logic [5:0] PIN_O,
    output logic [5:0] PIN_OE_N_O,
    output logic [5:0] PULLUP_EN_O,
    output logic [5:0] WAKE_EN_O,
    output logic WAKE_O,
    output logic MASTER_CLEAR_INPUT_N_O
);
    import sixp_pkg::*;
    logic [7:0] latch_reg;
    logic [7:0] dir_reg;
    logic [7:0] rdata_reg;
    logic [5:0] pin_prev_reg;
    logic [5:0] alt;
    sixp_pad_t pad;

    sixp_pin_ctl u_ctl (
        .cfg_i(CFG_I),
        .dir_i(dir_reg[5:0]),
        .pad_o(pad),
        .alt_o(alt)
    );

    // Direction register: written only by the direction-load strobe
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            dir_reg <= DIR_RESET;
        end else if (CE_I && DIR_LOAD_I) begin
            dir_reg <= WDATA_I;
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            latch_reg <= LATCH_RESET;
        end else if (CE_I && DATA_WR_I) begin
            latch_reg <= WDATA_I;
        end
    end

    // Read returns sampled pin levels, zero on alternate-function pins; direction is never readable
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            rdata_reg <= 8'h00;
        end else if (CE_I && DATA_RD_I) begin
            rdata_reg <= {2'b00, PIN_I & ~alt};
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            // Start from the live levels so release shows no false change
            pin_prev_reg <= PIN_I;
        end else if (CE_I) begin
            pin_prev_reg <= PIN_I;
        end
    end

    assign RDATA_O = rdata_reg;
    assign PIN_O = latch_reg[5:0];
    assign PIN_OE_N_O = pad.drive_n;
    assign PULLUP_EN_O = pad.pull_en;
    assign WAKE_EN_O = pad.wake_en;
    assign WAKE_O = |((PIN_I ^ pin_prev_reg) & pad.wake_en);
    assign MASTER_CLEAR_INPUT_N_O = CFG_I.master_clear_input_en ? PIN_I[PIN_INONLY] : 1'b1;

    rst_dir_a: assert property (@(posedge MCLK_I)
        $rose(RST_N_I) |-> PIN_OE_N_O == PIN_MASK)
        else $error("direction not all inputs after reset");
    inonly_a: assert property (@(posedge MCLK_I)
        disable iff (!RST_N_I) PIN_OE_N_O[PIN_INONLY])
        else $error("input-only pin driven");
    read_pins_a: assert property (@(posedge MCLK_I)
        disable iff (!RST_N_I) CE_I && DATA_RD_I
        |=> RDATA_O == {2'b00, $past(PIN_I) & ~$past(alt)})
        else $error("read not pin levels");
    upper_zero_a: assert property (@(posedge MCLK_I)
        disable iff (!RST_N_I) RDATA_O[7:6] == 2'b00)
        else $error("upper bits nonzero");
    dir_load_a: assert property (@(posedge MCLK_I)
        disable iff (!RST_N_I) CE_I && DIR_LOAD_I && !CFG_I.timer_from_pin
        && CFG_I.alt_func == 6'h00 && CFG_I.osc_sel > crystal_mode
        |=> PIN_OE_N_O[1:0] == $past(WDATA_I[1:0]))
        else $error("direction load not applied");
    dir_only_a: assert property (@(posedge MCLK_I)
        disable iff (!RST_N_I) !(CE_I && DIR_LOAD_I) |=> $stable(dir_reg))
        else $error("direction changed without load");
    latch_hold_a: assert property (@(posedge MCLK_I)
        disable iff (!RST_N_I) !(CE_I && DATA_WR_I) |=> $stable(PIN_O))
        else $error("latch changed without write");
    ce_hold_a: assert property (@(posedge MCLK_I)
        disable iff (!RST_N_I) !CE_I
        |=> $stable(latch_reg) && $stable(dir_reg) && $stable(RDATA_O))
        else $error("state moved with enable low");
    rd_hold_a: assert property (@(posedge MCLK_I)
        disable iff (!RST_N_I) !(CE_I && DATA_RD_I) |=> $stable(RDATA_O))
        else $error("read data changed without read");
    timer_in_a: assert property (@(posedge MCLK_I)
        disable iff (!RST_N_I) CFG_I.timer_from_pin |-> PIN_OE_N_O[PIN_TIMER])
        else $error("timer pin driven");
    master_clear_input_pull_a: assert property (@(posedge MCLK_I)
        disable iff (!RST_N_I) CFG_I.master_clear_input_en
        |-> PULLUP_EN_O[PIN_INONLY] && !WAKE_EN_O[PIN_INONLY])
        else $error("master clear pull or wake wrong");
    master_clear_input_off_a: assert property (@(posedge MCLK_I)
        disable iff (!RST_N_I) !CFG_I.master_clear_input_en |-> MASTER_CLEAR_INPUT_N_O)
        else $error("master clear active while disabled");
    shared_a: assert property (@(posedge MCLK_I)
        disable iff (!RST_N_I) (PULLUP_EN_O & ~WEAK_PIN_MASK) == 6'h00
        && (WAKE_EN_O & ~WEAK_PIN_MASK) == 6'h00)
        else $error("weak pull on wrong pin");
    alt_zero_a: assert property (@(posedge MCLK_I)
        disable iff (!RST_N_I) CE_I && DATA_RD_I
        && CFG_I.osc_sel == crystal_mode |=> RDATA_O[5:4] == 2'b00)
        else $error("oscillator pins read nonzero");
endmodule : sixp_port

// file: sixp_pkg.sv
package sixp_pkg;
    localparam int DATA_W = 8;
    localparam int PIN_N = 6;
    localparam int PIN_TIMER = 2;
    localparam int PIN_INONLY = 3;
    localparam int PIN_OSC_OUT = 4;
    localparam int PIN_OSC_IN = 5;
    localparam logic [7:0] DIR_RESET = 8'hFF;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [5:0] WEAK_PIN_MASK = 6'h0B;
    localparam logic [5:0] PIN_MASK = 6'h3F;

    typedef enum logic [1:0] {
        low_power_crystal_mode = 2'h0,
        crystal_mode = 2'h1,
        internal_rc_mode = 2'h2,
        external_rc_mode = 2'h3
    } sixp_osc_t;

    typedef struct packed {
        logic [5:0] alt_func;
        logic pullup_en;
        logic wake_en;
        logic master_clear_input_en;
        logic timer_from_pin;
        sixp_osc_t osc_sel;
    } sixp_cfg_t;

    typedef struct packed {
        logic [5:0] drive_n;
        logic [5:0] pull_en;
        logic [5:0] wake_en;
    } sixp_pad_t;
endpackage : sixp_pkg

// file: sixp_pin_ctl.sv
`timescale 1ns/1ps
module sixp_pin_ctl
    import sixp_pkg::*;
(
    input wire sixp_pkg::sixp_cfg_t cfg_i,
    input wire logic [5:0] dir_i,
    output sixp_pkg::sixp_pad_t pad_o,
    output logic [5:0] alt_o
);
    import sixp_pkg::*;
    logic [5:0] alt;
    always_comb begin
        alt = cfg_i.alt_func;
        if (cfg_i.osc_sel == low_power_crystal_mode ||
            cfg_i.osc_sel == crystal_mode) begin
            alt[PIN_OSC_OUT] = 1'b1;
            alt[PIN_OSC_IN] = 1'b1;
        end
        if (cfg_i.master_clear_input_en) begin
            alt[PIN_INONLY] = 1'b1;
        end
        if (cfg_i.timer_from_pin) begin
            alt[PIN_TIMER] = 1'b1;
        end
    end
    assign alt_o = alt;

    always_comb begin
        pad_o.drive_n = dir_i | alt;
        pad_o.drive_n[PIN_INONLY] = 1'b1;
        if (cfg_i.timer_from_pin) begin
            pad_o.drive_n[PIN_TIMER] = 1'b1;
        end
        pad_o.pull_en = cfg_i.pullup_en ? WEAK_PIN_MASK : 6'h00;
        pad_o.wake_en = cfg_i.wake_en ? WEAK_PIN_MASK : 6'h00;
        if (cfg_i.master_clear_input_en) begin
            pad_o.pull_en[PIN_INONLY] = 1'b1;
            pad_o.wake_en[PIN_INONLY] = 1'b0;
        end
    end
endmodule : sixp_pin_ctl

// file: sixp_ext.sv
`timescale 1ns/1ps
module sixp_ext (
    input wire logic clk_i,
    input wire logic [5:0] pin_o_i,
    input wire logic [5:0] oe_n_i,
    input wire logic [5:0] pull_i,
    input wire logic [5:0] ext_en_i,
    input wire logic [5:0] ext_i,
    output logic [5:0] lvl_o
);
    logic [5:0] last_reg = 6'h00;
    always_comb begin
        for (int k = 0; k < 6; k++) begin
            if (!oe_n_i[k]) lvl_o[k] = pin_o_i[k];
            else if (ext_en_i[k]) lvl_o[k] = ext_i[k];
            else if (pull_i[k]) lvl_o[k] = 1'b1;
            else lvl_o[k] = ~last_reg[k];
        end
    end
    // Floating pins toggle so a stale level is never read back
    always @(posedge clk_i) last_reg <= lvl_o;
endmodule : sixp_ext

// file: test_six_pin_io_port.sv
`timescale 1ns/1ps
module test_six_pin_io_port;
    import sixp_pkg::*;
    logic clk = 0, rst_n = 0, wr = 0, ld = 0, rd = 0, ce = 1, wake, master_clear_input_n;
    logic [7:0] wd = 8'h00, rdata;
    logic [5:0] ext = 6'h00, lvl, pin_o, oe_n, pull, wen;
    logic [5:0] ext_en = 6'h3F;
    sixp_cfg_t cfg = '{6'h00, 1'b0, 1'b0, 1'b0, 1'b0, internal_rc_mode};
    int bad_count = 0, checks_done = 0, cyc = 0;
    initial forever #5 clk = ~clk;
    sixp_port DUT (.MCLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .CFG_I(cfg),
        .DATA_WR_I(wr), .DIR_LOAD_I(ld), .WDATA_I(wd), .DATA_RD_I(rd),
        .RDATA_O(rdata), .PIN_I(lvl), .PIN_O(pin_o), .PIN_OE_N_O(oe_n),
        .PULLUP_EN_O(pull), .WAKE_EN_O(wen), .WAKE_O(wake),
        .MASTER_CLEAR_INPUT_N_O(master_clear_input_n));
    sixp_ext M (.clk_i(clk), .pin_o_i(pin_o), .oe_n_i(oe_n), .pull_i(pull),
        .ext_en_i(ext_en), .ext_i(ext), .lvl_o(lvl));
    task automatic chk(input string nm, input logic [7:0] e, g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic op(input logic w, l, r, input logic [7:0] d);
        @(negedge clk);
        {wr, ld, rd, wd} = {w, l, r, d};
        @(negedge clk);
        {wr, ld, rd} = 3'b000;
    endtask : op
    task automatic rdc(input logic [7:0] e);
        op(0, 0, 1, 8'h00);
        chk("rdata", e, rdata);
    endtask : rdc
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            bad_count++;
            conclude();
        end
    end
    initial begin
        repeat (3) @(negedge clk);
        rst_n = 1;
        chk("oe", 8'h3F, {2'b00, oe_n});
        chk("rdata", 8'h00, rdata);
        ext = 6'h2A;
        rdc(8'h2A);
        op(1, 0, 0, 8'hD5);
        chk("latch", 8'h15, {2'b00, pin_o});
        chk("oe", 8'h3F, {2'b00, oe_n});
        op(0, 1, 0, 8'h00);
        chk("oe", 8'h08, {2'b00, oe_n});
        rdc(8'h1D);
        ext = 6'h3F;
        op(0, 1, 0, 8'hFF);
        chk("latch", 8'h15, {2'b00, pin_o});
        rdc(8'h3F);
        op(0, 1, 0, 8'h00);
        cfg.timer_from_pin = 1;
        #1 chk("oe", 8'h0C, {2'b00, oe_n});
        rdc(8'h19);
        cfg.timer_from_pin = 0;
        cfg.alt_func = 6'h01;
        rdc(8'h1C);
        cfg.alt_func = 6'h00;
        for (int m = 0; m < 4; m++) begin
            cfg.osc_sel = sixp_osc_t'(m);
            #1 chk("oe", m < 2 ? 8'h38 : 8'h08, {2'b00, oe_n});
            rdc(m < 2 ? 8'h0D : 8'h1D);
        end
        cfg.osc_sel = internal_rc_mode;
        cfg.pullup_en = 1;
        #1 chk("pull", 8'h0B, {2'b00, pull});
        chk("wake", 8'h00, {2'b00, wen});
        {cfg.pullup_en, cfg.wake_en, cfg.master_clear_input_en} = 3'b011;
        ext = 6'h37;
        #1 chk("pull", 8'h08, {2'b00, pull});
        chk("wake", 8'h03, {2'b00, wen});
        chk("master_clear_input", 8'h00, {7'h00, master_clear_input_n});
        cfg.master_clear_input_en = 0;
        #1 chk("wake", 8'h0B, {2'b00, wen});
        chk("master_clear_input", 8'h01, {7'h00, master_clear_input_n});
        @(negedge clk);
        ext = 6'h3F;
        #1 chk("wake_o", 8'h01, {7'h00, wake});
        @(negedge clk);
        chk("wake_o", 8'h00, {7'h00, wake});
        cfg.master_clear_input_en = 1;
        ext_en = 6'h37;
        #1 chk("master_clear_input", 8'h01, {7'h00, master_clear_input_n});
        ext_en = 6'h3F;
        ext = 6'h37;
        #1 chk("wake_o", 8'h00, {7'h00, wake});
        chk("master_clear_input", 8'h00, {7'h00, master_clear_input_n});
        cfg.master_clear_input_en = 0;
        @(negedge clk);
        ce = 0;
        op(1, 1, 1, 8'h2A);
        chk("latch", 8'h15, {2'b00, pin_o});
        chk("oe", 8'h08, {2'b00, oe_n});
        chk("rdata", 8'h1D, rdata);
        ce = 1;
        rst_n = 0;
        repeat (3) @(negedge clk);
        rst_n = 1;
        chk("oe", 8'h3F, {2'b00, oe_n});
        chk("latch", 8'h00, {2'b00, pin_o});
        chk("rdata", 8'h00, rdata);
        chk("wake_o", 8'h00, {7'h00, wake});
        conclude();
    end
endmodule : test_six_pin_io_port
